// ---- rtl/sfq_pkg.sv ----
// Constants for the serial flash program, erase and power sequencer
package sfq_pkg;
	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [7:0] OPC_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OPC_SECTOR_CLEAR = 8'hd8;
	localparam logic [7:0] OPC_ARRAY_CLEAR = 8'hc7;
	localparam logic [7:0] OPC_SLEEP_ENTRY = 8'hb9;
	localparam logic [7:0] OPC_WAKE_SIG = 8'hab;
	localparam logic [7:0] OPC_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OPC_STATUS_READ = 8'h05;
	// ----------------------------------------
	// Framing
	// ----------------------------------------
	localparam logic [3:0] BYTES_OPC = 4'h1;
	localparam logic [3:0] BYTES_ADDR_END = 4'h4;
	localparam logic [3:0] BYTES_PAGE_MIN = 4'h5;
	localparam logic [3:0] BYTES_SAT = 4'hf;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int PAGE_BYTES = 256;
	localparam logic [8:0] PAGE_END = 9'h100;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// ----------------------------------------
	// Status byte fields
	// ----------------------------------------
	localparam int STAT_WIP = 0;
	localparam int STAT_WEL = 1;
	localparam int STAT_BP_LO = 2;
	// ----------------------------------------
	// Array word operations
	// ----------------------------------------
	localparam logic [1:0] OP_PROGRAM = 2'h1;
	localparam logic [1:0] OP_SECTOR = 2'h2;
	localparam logic [1:0] OP_ARRAY = 2'h3;
	localparam int WORD_W = 34;
	// ----------------------------------------
	// Timing, plain defaults in ns
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int PAGE_WRITE_TIME_NS = 1000000;
	localparam int SECTOR_CLEAR_TIME_NS = 500000000;
	localparam int ARRAY_CLEAR_TIME_NS = 2000000000;
	localparam int SLEEP_ENTRY_DELAY_NS = 3000;
	localparam int WAKE_DELAY_NS = 3000;
	localparam int WAKE_WITH_SIGNATURE_DELAY_NS = 1800;
	// Least times: round up, never below one cycle
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS + ((ns % CLK_PERIOD_NS) != 0 ? 1 : 0);
		return (c < 1) ? 1 : c;
	endfunction
	localparam int PAGE_WRITE_CYC = ns_to_cyc(PAGE_WRITE_TIME_NS);
	localparam int SECTOR_CLEAR_CYC = ns_to_cyc(SECTOR_CLEAR_TIME_NS);
	localparam int ARRAY_CLEAR_CYC = ns_to_cyc(ARRAY_CLEAR_TIME_NS);
	localparam int SLEEP_ENTRY_CYC = ns_to_cyc(SLEEP_ENTRY_DELAY_NS);
	localparam int WAKE_CYC = ns_to_cyc(WAKE_DELAY_NS);
	localparam int WAKE_SIG_CYC = ns_to_cyc(WAKE_WITH_SIGNATURE_DELAY_NS);
	// Arbitrary signature value
	localparam logic [7:0] SIGNATURE_DEFAULT = 8'h5a;
endpackage

// ---- rtl/sfq_stream_if.sv ----
// Valid/ready word stream between sequencer modules
`timescale 1ns/1ps
interface sfq_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface // sfq_stream_if

// ---- rtl/sfq_buf.sv ----
// Two-entry buffer on the array word path
`timescale 1ns/1ps
module sfq_buf #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Streams
	sfq_stream_if.snk fill,
	sfq_stream_if.src drain
);
	logic [W-1:0] mem_reg [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] cnt_reg;
	logic push;
	logic pop;

	// Full at two; the drain side may stall and back-pressure the filler
	assign fill.ready = (cnt_reg != 2'h2);
	assign drain.valid = (cnt_reg != 2'h0);
	assign drain.data = mem_reg[rd_ptr_reg];
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
		end
		else if (push)
			mem_reg[wr_ptr_reg] <= fill.data;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= ~wr_ptr_reg;
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			if (push && !pop)
				cnt_reg <= cnt_reg + 2'h1;
			else if (pop && !push)
				cnt_reg <= cnt_reg - 2'h1;
		end
	end
endmodule // sfq_buf

// ---- rtl/sfq_core.sv ----
// Serial flash program, erase and power-down command sequencer
`timescale 1ns/1ps
module sfq_core #(
	parameter int PAGE_WRITE_CYC = sfq_pkg::PAGE_WRITE_CYC,
	parameter int SECTOR_CLEAR_CYC = sfq_pkg::SECTOR_CLEAR_CYC,
	parameter int ARRAY_CLEAR_CYC = sfq_pkg::ARRAY_CLEAR_CYC,
	parameter logic [7:0] SIGNATURE = sfq_pkg::SIGNATURE_DEFAULT
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Serial pins
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_en,
	// Protection setting
	input wire logic protect_size_bit2,
	input wire logic protect_size_bit1,
	input wire logic protect_size_bit0,
	// State
	output logic write_enable_latch,
	output logic write_in_progress_flag,
	output logic sleep_mode,
	// Array word stream
	output logic arr_valid,
	input wire logic arr_ready,
	output logic [sfq_pkg::WORD_W-1:0] arr_word
);
	typedef enum logic [1:0] {EX_IDLE, EX_EMIT, EX_WAIT} sfq_ex_type;
	typedef enum logic [1:0] {PW_ON, PW_ENTER, PW_SLEEP, PW_WAKE} sfq_pw_type;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Top 2^(bp-1) of the 64 sectors are protected, all at bp=7
	function automatic logic is_protected(input logic [2:0] bp,
		input logic [23:0] a);
		logic [6:0] n;
		n = (bp == 3'h0) ? 7'h00 : (7'h01 << (bp - 3'h1));
		return ({1'b0, a[21:16]} >= (7'h40 - n)) && (n != 7'h00);
	endfunction

	function automatic logic [31:0] cyc_load(input int c);
		return 32'(c - 1);
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic cs_s1_reg, cs_s2_reg, cs_prev_reg;
	logic sck_s1_reg, sck_s2_reg, sck_prev_reg;
	logic si_s1_reg, si_s2_reg;
	logic cs_low, cs_rise, sck_rise, sck_fall;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
			sck_s1_reg <= 1'b0;
			sck_s2_reg <= 1'b0;
			sck_prev_reg <= 1'b0;
			si_s1_reg <= 1'b0;
			si_s2_reg <= 1'b0;
		end
		else
		begin
			cs_s1_reg <= spi_cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_prev_reg <= cs_s2_reg;
			sck_s1_reg <= spi_sck;
			sck_s2_reg <= sck_s1_reg;
			sck_prev_reg <= sck_s2_reg;
			si_s1_reg <= serial_in;
			si_s2_reg <= si_s1_reg;
		end
	end

	assign cs_low = ~cs_s2_reg;
	assign cs_rise = cs_s2_reg && !cs_prev_reg;
	assign sck_rise = cs_low && sck_s2_reg && !sck_prev_reg;
	assign sck_fall = cs_low && !sck_s2_reg && sck_prev_reg;

	// ----------------------------------------
	// Receive side
	// ----------------------------------------
	logic [2:0] bit_cnt_reg;
	logic [3:0] byte_cnt_reg;
	logic [7:0] shift_reg, opc_reg, data_cnt_reg;
	logic [23:0] addr_reg;
	logic ign_reg;
	logic [7:0] nb;
	logic byte_done, busy, allowed;
	logic [2:0] bp;
	sfq_ex_type ex_state_reg;
	sfq_pw_type pw_state_reg;

	assign bp = {protect_size_bit2, protect_size_bit1, protect_size_bit0};
	assign busy = (ex_state_reg != EX_IDLE);
	assign nb = {shift_reg[6:0], si_s2_reg};
	assign byte_done = sck_rise && (bit_cnt_reg == sfq_pkg::BIT_LAST);

	always_comb
	begin
		unique case (pw_state_reg)
			PW_WAKE: allowed = 1'b0;
			PW_ENTER, PW_SLEEP:
				allowed = (nb == sfq_pkg::OPC_WAKE_SIG) && !busy;
			default:
				if (busy)
					allowed = (nb == sfq_pkg::OPC_STATUS_READ);
				else
					allowed = (nb == sfq_pkg::OPC_PAGE_WRITE)
						|| (nb == sfq_pkg::OPC_SECTOR_CLEAR)
						|| (nb == sfq_pkg::OPC_ARRAY_CLEAR)
						|| (nb == sfq_pkg::OPC_SLEEP_ENTRY)
						|| (nb == sfq_pkg::OPC_WAKE_SIG)
						|| (nb == sfq_pkg::OPC_WRITE_UNLOCK)
						|| (nb == sfq_pkg::OPC_STATUS_READ);
		endcase
	end

	// Counters restart whenever select is high, so a frame starts clean
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			opc_reg <= 8'h00;
			addr_reg <= 24'h000000;
			data_cnt_reg <= 8'h00;
			ign_reg <= 1'b1;
		end
		else if (!cs_low)
		begin
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 4'h0;
			data_cnt_reg <= 8'h00;
		end
		else if (sck_rise)
		begin
			shift_reg <= nb;
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (byte_done)
			begin
				if (byte_cnt_reg != sfq_pkg::BYTES_SAT)
					byte_cnt_reg <= byte_cnt_reg + 4'h1;
				if (byte_cnt_reg == 4'h0)
				begin
					opc_reg <= nb;
					ign_reg <= !allowed;
				end
				else if (byte_cnt_reg < sfq_pkg::BYTES_ADDR_END)
					addr_reg <= {addr_reg[15:0], nb};
				else
					data_cnt_reg <= data_cnt_reg + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// Page buffer
	// ----------------------------------------
	logic [7:0] page_mem [sfq_pkg::PAGE_BYTES];
	logic [sfq_pkg::PAGE_BYTES-1:0] mask_reg;
	logic [7:0] wr_idx;
	logic data_byte;

	// Index wraps within the page; later bytes overwrite earlier ones
	assign wr_idx = addr_reg[7:0] + data_cnt_reg;
	assign data_byte = byte_done && !ign_reg
		&& (byte_cnt_reg >= sfq_pkg::BYTES_ADDR_END)
		&& (opc_reg == sfq_pkg::OPC_PAGE_WRITE);

	always_ff @(posedge ref_clk)
	begin
		if (data_byte)
			page_mem[wr_idx] <= nb;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			mask_reg <= '0;
		else if (byte_done && byte_cnt_reg == 4'h0 && allowed
			&& nb == sfq_pkg::OPC_PAGE_WRITE)
			mask_reg <= '0;
		else if (data_byte)
			mask_reg[wr_idx] <= 1'b1;
	end

	// ----------------------------------------
	// Decision at the end of a frame
	// ----------------------------------------
	logic on_byte, ok, go_pp, go_se, go_be, go_write_unlock_cmd, go_dp, go_rel;

	assign on_byte = (bit_cnt_reg == 3'h0);
	assign ok = cs_rise && !ign_reg && on_byte;
	assign go_pp = ok && opc_reg == sfq_pkg::OPC_PAGE_WRITE
		&& byte_cnt_reg >= sfq_pkg::BYTES_PAGE_MIN
		&& write_enable_latch && !is_protected(bp, addr_reg);
	assign go_se = ok && opc_reg == sfq_pkg::OPC_SECTOR_CLEAR
		&& byte_cnt_reg == sfq_pkg::BYTES_ADDR_END
		&& write_enable_latch && !is_protected(bp, addr_reg);
	assign go_be = ok && opc_reg == sfq_pkg::OPC_ARRAY_CLEAR
		&& byte_cnt_reg == sfq_pkg::BYTES_OPC
		&& write_enable_latch && bp == 3'h0;
	assign go_write_unlock_cmd = ok && opc_reg == sfq_pkg::OPC_WRITE_UNLOCK
		&& byte_cnt_reg == sfq_pkg::BYTES_OPC;
	// Busy already forced the opcode to be ignored
	assign go_dp = ok && opc_reg == sfq_pkg::OPC_SLEEP_ENTRY
		&& byte_cnt_reg == sfq_pkg::BYTES_OPC;
	assign go_rel = ok && opc_reg == sfq_pkg::OPC_WAKE_SIG
		&& byte_cnt_reg >= sfq_pkg::BYTES_OPC;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			write_enable_latch <= 1'b0;
		else if (go_write_unlock_cmd)
			write_enable_latch <= 1'b1;
		else if (go_pp || go_se || go_be)
			write_enable_latch <= 1'b0;
	end

	// ----------------------------------------
	// Self-timed cycle
	// ----------------------------------------
	logic [1:0] ex_op_reg;
	logic [23:0] ex_addr_reg;
	logic [8:0] ex_idx_reg;
	logic [31:0] ex_cnt_reg;
	logic is_prog, skip, push_done;

	sfq_stream_if #(.W(sfq_pkg::WORD_W)) fill_if ();
	sfq_stream_if #(.W(sfq_pkg::WORD_W)) drain_if ();

	assign is_prog = (ex_op_reg == sfq_pkg::OP_PROGRAM);
	assign skip = is_prog && !ex_idx_reg[8] && !mask_reg[ex_idx_reg[7:0]];
	assign fill_if.valid = (ex_state_reg == EX_EMIT) && !ex_idx_reg[8]
		&& (!is_prog || mask_reg[ex_idx_reg[7:0]]);
	assign fill_if.data = is_prog
		? {ex_op_reg, ex_addr_reg[23:8], ex_idx_reg[7:0],
			page_mem[ex_idx_reg[7:0]]}
		: {ex_op_reg, ex_addr_reg, sfq_pkg::ERASED_BYTE};
	assign push_done = fill_if.valid && fill_if.ready;

	// Timer runs alongside emission; a stalled array only stretches busy
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ex_state_reg <= EX_IDLE;
			ex_op_reg <= sfq_pkg::OP_PROGRAM;
			ex_addr_reg <= 24'h000000;
			ex_idx_reg <= 9'h000;
			ex_cnt_reg <= 32'h00000000;
		end
		else
		begin
			unique case (ex_state_reg)
				EX_IDLE:
					if (go_pp || go_se || go_be)
					begin
						ex_state_reg <= EX_EMIT;
						ex_addr_reg <= addr_reg;
						ex_idx_reg <= 9'h000;
						if (go_pp)
						begin
							ex_op_reg <= sfq_pkg::OP_PROGRAM;
							ex_cnt_reg <= cyc_load(PAGE_WRITE_CYC);
						end
						else if (go_se)
						begin
							ex_op_reg <= sfq_pkg::OP_SECTOR;
							ex_cnt_reg <= cyc_load(SECTOR_CLEAR_CYC);
						end
						else
						begin
							ex_op_reg <= sfq_pkg::OP_ARRAY;
							ex_cnt_reg <= cyc_load(ARRAY_CLEAR_CYC);
						end
					end
				EX_EMIT:
				begin
					if (ex_cnt_reg != 32'h00000000)
						ex_cnt_reg <= ex_cnt_reg - 32'h00000001;
					if (!is_prog && push_done)
						ex_state_reg <= EX_WAIT;
					else if (ex_idx_reg == sfq_pkg::PAGE_END)
						ex_state_reg <= EX_WAIT;
					else if (skip || push_done)
						ex_idx_reg <= ex_idx_reg + 9'h001;
				end
				EX_WAIT:
					if (ex_cnt_reg == 32'h00000000)
						ex_state_reg <= EX_IDLE;
					else
						ex_cnt_reg <= ex_cnt_reg - 32'h00000001;
			endcase
		end
	end

	assign write_in_progress_flag = busy;

	sfq_buf #(.W(sfq_pkg::WORD_W)) u_buf (
		.ref_clk(ref_clk),
		.rst(rst),
		.fill(fill_if),
		.drain(drain_if)
	);

	assign arr_valid = drain_if.valid;
	assign arr_word = drain_if.data;
	assign drain_if.ready = arr_ready;

	// ----------------------------------------
	// Power state
	// ----------------------------------------
	logic [31:0] pw_cnt_reg;

	// Reset always lands awake; only the sleep opcode leaves PW_ON
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pw_state_reg <= PW_ON;
			pw_cnt_reg <= 32'h00000000;
		end
		else
		begin
			unique case (pw_state_reg)
				PW_ON:
					if (go_dp)
					begin
						pw_state_reg <= PW_ENTER;
						pw_cnt_reg <= cyc_load(sfq_pkg::SLEEP_ENTRY_CYC);
					end
				PW_ENTER, PW_SLEEP:
					if (go_rel)
					begin
						pw_state_reg <= PW_WAKE;
						if (byte_cnt_reg >= sfq_pkg::BYTES_ADDR_END)
							pw_cnt_reg <= cyc_load(sfq_pkg::WAKE_SIG_CYC);
						else
							pw_cnt_reg <= cyc_load(sfq_pkg::WAKE_CYC);
					end
					else if (pw_state_reg == PW_ENTER)
					begin
						if (pw_cnt_reg == 32'h00000000)
							pw_state_reg <= PW_SLEEP;
						else
							pw_cnt_reg <= pw_cnt_reg - 32'h00000001;
					end
				PW_WAKE:
					if (pw_cnt_reg == 32'h00000000)
						pw_state_reg <= PW_ON;
					else
						pw_cnt_reg <= pw_cnt_reg - 32'h00000001;
			endcase
		end
	end

	assign sleep_mode = (pw_state_reg == PW_SLEEP);

	// ----------------------------------------
	// Serial output
	// ----------------------------------------
	logic [7:0] out_sh_reg, out_byte, status_byte;
	logic out_active;

	always_comb
	begin
		status_byte = 8'h00;
		status_byte[sfq_pkg::STAT_WIP] = busy;
		status_byte[sfq_pkg::STAT_WEL] = write_enable_latch;
		status_byte[sfq_pkg::STAT_BP_LO +: 3] = bp;
	end

	assign out_byte = (opc_reg == sfq_pkg::OPC_STATUS_READ)
		? status_byte : SIGNATURE;
	assign out_active = !ign_reg && byte_cnt_reg != 4'h0
		&& ((opc_reg == sfq_pkg::OPC_STATUS_READ)
		|| (opc_reg == sfq_pkg::OPC_WAKE_SIG
		&& byte_cnt_reg >= sfq_pkg::BYTES_ADDR_END));

	// Byte reloads every eighth fall, so the value repeats until deselect
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			serial_out <= 1'b0;
			serial_out_en <= 1'b0;
			out_sh_reg <= 8'h00;
		end
		else
		begin
			serial_out_en <= cs_low && out_active;
			if (sck_fall && out_active)
			begin
				if (bit_cnt_reg == 3'h0)
				begin
					serial_out <= out_byte[7];
					out_sh_reg <= {out_byte[6:0], 1'b0};
				end
				else
				begin
					serial_out <= out_sh_reg[7];
					out_sh_reg <= {out_sh_reg[6:0], 1'b0};
				end
			end
		end
	end
endmodule // sfq_core

// ---- tb/sfq_core_asserts.sv ----
// Port-level checks on the flash command sequencer
`timescale 1ns/1ps
module sfq_core_asserts (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Watched ports
	input wire logic spi_cs_n,
	input wire logic serial_out_en,
	input wire logic write_enable_latch,
	input wire logic write_in_progress_flag,
	input wire logic sleep_mode,
	input wire logic arr_valid,
	input wire logic arr_ready,
	input wire logic [sfq_pkg::WORD_W-1:0] arr_word
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_up_awake;
		$fell(rst) |-> !write_enable_latch && !write_in_progress_flag
			&& !sleep_mode;
	endproperty
	a_up_awake: assert property (p_up_awake)
		else $error("state not clear after reset");
	property p_start_deselected;
		$rose(write_in_progress_flag) |-> spi_cs_n;
	endproperty
	a_start_deselected: assert property (p_start_deselected)
		else $error("cycle started while selected");
	property p_latch_drop;
		$rose(write_in_progress_flag) |-> ##[0:2] !write_enable_latch;
	endproperty
	a_latch_drop: assert property (p_latch_drop)
		else $error("latch kept after cycle start");
	property p_first_word;
		$rose(write_in_progress_flag) |-> ##[1:4] arr_valid;
	endproperty
	a_first_word: assert property (p_first_word)
		else $error("no array word after cycle start");
	property p_word_in_cycle;
		$rose(arr_valid) |-> write_in_progress_flag;
	endproperty
	a_word_in_cycle: assert property (p_word_in_cycle)
		else $error("array word outside a cycle");
	property p_word_hold;
		arr_valid && !arr_ready |=> arr_valid && $stable(arr_word);
	endproperty
	a_word_hold: assert property (p_word_hold)
		else $error("stalled word lost or changed");
	property p_erase_ones;
		arr_valid && arr_word[33:32] != 2'h1 |-> arr_word[7:0] == 8'hff;
	endproperty
	a_erase_ones: assert property (p_erase_ones)
		else $error("erase word not all ones");
	property p_sleep_late;
		$rose(sleep_mode) |-> spi_cs_n && $past(spi_cs_n, 8);
	endproperty
	a_sleep_late: assert property (p_sleep_late)
		else $error("sleep entered too early");
	property p_sleep_idle;
		sleep_mode |-> !write_in_progress_flag;
	endproperty
	a_sleep_idle: assert property (p_sleep_idle)
		else $error("asleep during a cycle");
	property p_sleep_locked;
		sleep_mode |=> !$rose(write_enable_latch);
	endproperty
	a_sleep_locked: assert property (p_sleep_locked)
		else $error("latch set while asleep");
	property p_out_release;
		$rose(spi_cs_n) |-> ##[0:6] !serial_out_en;
	endproperty
	a_out_release: assert property (p_out_release)
		else $error("output still driven after deselect");
endmodule // sfq_core_asserts

// ---- tb/sfq_host_model.sv ----
// Host serial controller model driving select, clock and data
`timescale 1ns/1ps
module sfq_host_model (
	// Clock
	input wire logic ref_clk,
	// Serial pins
	output logic spi_cs_n,
	output logic spi_sck,
	output logic serial_in,
	input wire logic serial_out
);
	logic [7:0] tx [0:299];
	logic [7:0] rx [0:299];
	initial
	begin
		spi_cs_n = 1'b1;
		spi_sck = 1'b0;
		serial_in = 1'b0;
	end
	task automatic half;
		repeat (8) @(negedge ref_clk);
	endtask
	// Clock stands low outside frames; select held low all frame
	task automatic xfer(input int nb, input int xb);
		int i;
		@(negedge ref_clk);
		spi_cs_n = 1'b0;
		for (i = 0; i < nb * 8 + xb; i++)
		begin
			serial_in = tx[i / 8][7 - i % 8];
			half;
			spi_sck = 1'b1;
			rx[i / 8][7 - i % 8] = serial_out;
			half;
			spi_sck = 1'b0;
		end
		half;
		spi_cs_n = 1'b1;
		// Released line shows a changed level, not the last bit
		serial_in = ~serial_in;
		half;
	endtask
endmodule // sfq_host_model

// ---- tb/sfq_core_bench.sv ----
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module sfq_core_bench;
	logic ref_clk, rst, spi_cs_n, spi_sck, serial_in, serial_out;
	logic serial_out_en, write_enable_latch, write_in_progress_flag;
	logic sleep_mode, arr_valid, arr_ready, stall;
	logic so_line;
	logic [2:0] bp;
	logic [sfq_pkg::WORD_W-1:0] arr_word;
	logic [sfq_pkg::WORD_W-1:0] got [$];
	int miscompares, samples_checked;
	// Sector cycle kept long so frames fit inside it
	sfq_core #(.PAGE_WRITE_CYC(50), .SECTOR_CLEAR_CYC(2000),
		.ARRAY_CLEAR_CYC(50)) u_dut (.ref_clk(ref_clk), .rst(rst),
		.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_en(serial_out_en),
		.protect_size_bit2(bp[2]), .protect_size_bit1(bp[1]),
		.protect_size_bit0(bp[0]), .write_enable_latch(write_enable_latch),
		.write_in_progress_flag(write_in_progress_flag),
		.sleep_mode(sleep_mode), .arr_valid(arr_valid),
		.arr_ready(arr_ready), .arr_word(arr_word));
	sfq_host_model u_host (.ref_clk(ref_clk), .spi_cs_n(spi_cs_n),
		.spi_sck(spi_sck), .serial_in(serial_in), .serial_out(so_line));
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Undriven line shows the inverse, so a missing drive cannot pass
	assign so_line = serial_out_en ? serial_out : ~serial_out;
	always @(negedge ref_clk) arr_ready <= !stall;
	always @(posedge ref_clk)
		if (arr_valid === 1'b1 && arr_ready === 1'b1)
			got.push_back(arr_word);
	// ----
	// Helpers
	// ----
	task automatic chk(input logic [33:0] e, input logic [33:0] g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic flags(input logic [3:0] e);
		chk({30'h0, e}, {30'h0, write_enable_latch, write_in_progress_flag,
			sleep_mode, arr_valid});
	endtask
	task automatic cmd(input logic [7:0] op, input logic [23:0] a,
		input int nb, input int xb);
		u_host.tx[0] = op;
		u_host.tx[1] = a[23:16];
		u_host.tx[2] = a[15:8];
		u_host.tx[3] = a[7:0];
		u_host.xfer(nb, xb);
	endtask
	task automatic idle;
		int n;
		n = 0;
		while (write_in_progress_flag !== 1'b0 && n < 5000)
		begin
			@(negedge ref_clk);
			n++;
		end
		// A cycle that never ends is a failure, not a pass
		if (write_in_progress_flag !== 1'b0)
			miscompares++;
		repeat (10) @(negedge ref_clk);
	endtask
	task automatic stop_test;
		$display("samples_checked=%0d miscompares=%0d", samples_checked,
			miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_no_latch;
		flags(4'h0);
		u_host.tx[4] = 8'h11;
		cmd(8'h02, 24'h000010, 5, 0);
		flags(4'h0);
	endtask
	task automatic t_wrap;
		int j;
		cmd(8'h06, 24'h0, 1, 0);
		flags(4'h8);
		got.delete();
		stall = 1'b1;
		for (j = 0; j < 4; j++)
			u_host.tx[4 + j] = 8'ha0 + 8'(j);
		cmd(8'h02, 24'h0201fe, 8, 0);
		cmd(8'h05, 24'h0, 2, 0);
		chk(34'(u_host.rx[1]), 34'h1);
		flags(4'h5);
		stall = 1'b0;
		idle;
		chk(34'(got.size()), 34'h4);
		for (j = 0; j < 4; j++)
			chk({2'h1, 16'h0201, 8'hfe + 8'((j + 2) % 4),
				8'ha0 + 8'((j + 2) % 4)}, got[j]);
	endtask
	task automatic t_over;
		int j;
		for (j = 0; j < 258; j++)
			u_host.tx[4 + j] = 8'(j) + 8'(j / 256);
		cmd(8'h06, 24'h0, 1, 0);
		got.delete();
		cmd(8'h02, 24'h0, 262, 0);
		idle;
		chk(34'(got.size()), 34'h100);
		for (j = 0; j < 256; j++)
			chk({2'h1, 16'h0, 8'(j), 8'(j) + 8'(j < 2)}, got[j]);
	endtask
	task automatic t_bad_len;
		logic [7:0] ops [3] = '{8'h02, 8'hd8, 8'hc7};
		int nbs [3] = '{5, 5, 2};
		int xbs [3] = '{3, 0, 0};
		int j;
		cmd(8'h06, 24'h0, 1, 0);
		for (j = 0; j < 3; j++)
		begin
			cmd(ops[j], 24'h0, nbs[j], xbs[j]);
			flags(4'h8);
		end
	endtask
	task automatic t_protect;
		bp = 3'h1;
		cmd(8'hd8, 24'h3f1234, 4, 0);
		flags(4'h8);
		cmd(8'h02, 24'h3fff00, 5, 0);
		flags(4'h8);
		cmd(8'hc7, 24'h0, 1, 0);
		flags(4'h8);
		got.delete();
		cmd(8'hd8, 24'h3e1234, 4, 0);
		idle;
		chk({2'h2, 24'h3e1234, 8'hff}, got[0]);
		bp = 3'h0;
		cmd(8'h06, 24'h0, 1, 0);
		got.delete();
		cmd(8'hc7, 24'h0, 1, 0);
		idle;
		chk({24'h0, 2'h3, 8'hff}, {24'h0, got[0][33:32], got[0][7:0]});
	endtask
	task automatic t_sleep;
		cmd(8'hb9, 24'h0, 1, 0);
		flags(4'h0);
		repeat (320) @(negedge ref_clk);
		flags(4'h2);
		cmd(8'h06, 24'h0, 1, 0);
		flags(4'h2);
		cmd(8'hab, 24'h0, 1, 0);
		repeat (320) @(negedge ref_clk);
		flags(4'h0);
		cmd(8'h06, 24'h0, 1, 0);
		flags(4'h8);
		cmd(8'hab, 24'h0, 6, 0);
		chk(34'(u_host.rx[4]), 34'(sfq_pkg::SIGNATURE_DEFAULT));
		chk(34'(u_host.rx[5]), 34'(sfq_pkg::SIGNATURE_DEFAULT));
		cmd(8'hb9, 24'h0, 1, 0);
		repeat (320) @(negedge ref_clk);
		flags(4'ha);
		cmd(8'hab, 24'h0, 6, 0);
		chk(34'(u_host.rx[4]), 34'(sfq_pkg::SIGNATURE_DEFAULT));
		flags(4'h8);
		repeat (200) @(negedge ref_clk);
		cmd(8'h05, 24'h0, 2, 0);
		chk(34'(u_host.rx[1]), 34'h2);
	endtask
	task automatic t_busy_reject;
		cmd(8'hd8, 24'h100000, 4, 0);
		cmd(8'hb9, 24'h0, 1, 0);
		cmd(8'hab, 24'h0, 6, 0);
		flags(4'h4);
		idle;
		repeat (320) @(negedge ref_clk);
		flags(4'h0);
	endtask
	initial
	begin
		rst = 1'b1;
		bp = 3'h0;
		stall = 1'b0;
		miscompares = 0;
		samples_checked = 0;
		repeat (6) @(negedge ref_clk);
		rst = 1'b0;
		repeat (4) @(negedge ref_clk);
		t_no_latch;
		t_wrap;
		t_over;
		t_bad_len;
		t_protect;
		t_sleep;
		t_busy_reject;
		stop_test;
	end
	initial
	begin
		#900000;
		miscompares++;
		stop_test;
	end
endmodule // sfq_core_bench
bind sfq_core sfq_core_asserts u_chk (.ref_clk(ref_clk), .rst(rst),
	.spi_cs_n(spi_cs_n), .serial_out_en(serial_out_en),
	.write_enable_latch(write_enable_latch),
	.write_in_progress_flag(write_in_progress_flag),
	.sleep_mode(sleep_mode), .arr_valid(arr_valid), .arr_ready(arr_ready),
	.arr_word(arr_word));
